// ===== core/fwsr_map.vh
// Summary of operation
// - After a timeout the host writes reset before any new program or erase.
// - Host reads all data lines twice in a row and compares the toggle bit.
// - Toggle stopped means finished; array data is valid on the next read.
// - Still toggling: check timeout flag, retest toggle, reset if it still toggles.
// - After breaking off, the command ends with the timeout flag set; polling does not restart.
// - Host reads window flag before and after each added sector erase command; the code refuses one unread once its own window timer has run out.
// - Write starts only with chip select and write enable low, output enable high.
// - Each added sector load starts within 50us of the previous write strobe.
`ifndef FWSR_MAP_VH
`define FWSR_MAP_VH

`define FWSR_CLK_NS        25
`define FWSR_T_WP_NS       35
`define FWSR_T_WPH_NS      30
`define FWSR_T_ACC_NS      70
`define FWSR_T_OEH_NS      10
`define FWSR_T_WIN_US      50
`define FWSR_WP_CYC        ((`FWSR_T_WP_NS + `FWSR_CLK_NS - 1) / `FWSR_CLK_NS)
`define FWSR_WPH_CYC       ((`FWSR_T_WPH_NS + `FWSR_CLK_NS - 1) / `FWSR_CLK_NS)
`define FWSR_ACC_CYC       ((`FWSR_T_ACC_NS + `FWSR_CLK_NS - 1) / `FWSR_CLK_NS)
`define FWSR_OEH_CYC       ((`FWSR_T_OEH_NS + `FWSR_CLK_NS - 1) / `FWSR_CLK_NS)
`define FWSR_WIN_CYC       ((`FWSR_T_WIN_US * 1000) / `FWSR_CLK_NS)

`define FWSR_BIT_POLL      7
`define FWSR_BIT_BUSY_TGL  6
`define FWSR_BIT_TIMING    5
`define FWSR_BIT_WINDOW    3
`define FWSR_BIT_SECT_TGL  2

`define FWSR_ADDR_UNLOCK1  20'h0_0555
`define FWSR_ADDR_UNLOCK2  20'h0_02AA
`define FWSR_DAT_UNLOCK1   8'hAA
`define FWSR_DAT_UNLOCK2   8'h55
`define FWSR_DAT_PROG      8'hA0
`define FWSR_DAT_ERASE_SU  8'h80
`define FWSR_DAT_SECT_ERS  8'h30
`define FWSR_DAT_RESET     8'hF0

`define FWSR_OP_READ       3'h0
`define FWSR_OP_PROG       3'h1
`define FWSR_OP_ERASE      3'h2
`define FWSR_OP_ADD_SECT   3'h3
`define FWSR_OP_POLL       3'h4
`define FWSR_OP_RESET      3'h5

`endif

// ===== core/fwsr_bus_cycle.v
`timescale 1ns/10ps
`include "fwsr_map.vh"
module fwsr_bus_cycle #(
  parameter AW      = 20,
  parameter WP_CYC  = `FWSR_WP_CYC,
  parameter WPH_CYC = `FWSR_WPH_CYC,
  parameter ACC_CYC = `FWSR_ACC_CYC,
  parameter OEH_CYC = `FWSR_OEH_CYC
) (
  input  wire          sys_clk_in,     // System clock
  input  wire          sys_rst_in,     // Synchronous reset, high
  input  wire          go_in,          // Start one bus cycle
  input  wire          wr_in,          // 1 write, 0 read
  input  wire [AW-1:0] addr_in,        // Cycle address
  input  wire [7:0]    wdata_in,       // Write data
  output wire          idle_out,       // Ready for go_in
  output reg           done_ff,        // One-cycle pulse at cycle end
  output reg  [7:0]    rdata_ff,       // Captured read data
  output reg  [AW-1:0] flash_addr_out, // Address pins
  output reg  [7:0]    flash_data_out, // Data pins, out
  output reg           flash_data_oe_n_out, // Data drive, low drives
  input  wire [7:0]    flash_data_in,  // Data pins, in
  output reg           flash_ce_n_out, // Chip select
  output reg           flash_we_n_out, // Write enable
  output reg           flash_oe_n_out  // Output enable
);

  localparam S_IDLE = 2'd0;
  localparam S_ACT  = 2'd1;
  localparam S_REC  = 2'd2;

  reg [1:0] state_ff;
  reg [3:0] cnt_ff;
  reg       wr_ff;

  assign idle_out = (state_ff == S_IDLE);

  ////////////////////////////////////////////////////////////////
  always @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      state_ff            <= S_IDLE;
      cnt_ff              <= 4'h0;
      wr_ff               <= 1'b0;
      done_ff             <= 1'b0;
      rdata_ff            <= 8'h00;
      flash_addr_out      <= {AW{1'b0}};
      flash_data_out      <= 8'h00;
      flash_data_oe_n_out <= 1'b1;
      flash_ce_n_out      <= 1'b1;
      flash_we_n_out      <= 1'b1;
      flash_oe_n_out      <= 1'b1;
    end
    else
    begin
      done_ff <= 1'b0;
      case (state_ff)
        S_IDLE:
        begin
          if (go_in)
          begin
            state_ff            <= S_ACT;
            wr_ff               <= wr_in;
            flash_addr_out      <= addr_in;
            flash_data_out      <= wdata_in;
            flash_data_oe_n_out <= ~wr_in;
            flash_ce_n_out      <= 1'b0;
            // Output enable held high for the whole write keeps the logical inhibit open
            flash_oe_n_out      <= wr_in;
            flash_we_n_out      <= ~wr_in;
            cnt_ff              <= wr_in ? WP_CYC[3:0] : ACC_CYC[3:0];
          end
        end
        S_ACT:
        begin
          if (cnt_ff <= 4'h1)
          begin
            state_ff <= S_REC;
            if (!wr_ff)
              rdata_ff <= flash_data_in;
            flash_we_n_out <= 1'b1;
            flash_oe_n_out <= 1'b1;
            flash_ce_n_out <= 1'b1;
            cnt_ff         <= wr_ff ? WPH_CYC[3:0] : OEH_CYC[3:0];
          end
          else
            cnt_ff <= cnt_ff - 4'h1;
        end
        S_REC:
        begin
          flash_data_oe_n_out <= 1'b1;
          if (cnt_ff <= 4'h1)
          begin
            state_ff <= S_IDLE;
            done_ff  <= 1'b1;
          end
          else
            cnt_ff <= cnt_ff - 4'h1;
        end
        default:
          state_ff <= S_IDLE;
      endcase
    end
  end

endmodule // fwsr_bus_cycle

// ===== core/fwsr_host_ctrl.v
`timescale 1ns/10ps
`include "fwsr_map.vh"
module fwsr_host_ctrl #(
  parameter AW      = 20,
  parameter WIN_CYC = `FWSR_WIN_CYC
) (
  input  wire          sys_clk_in,          // System clock, 40 MHz
  input  wire          sys_rst_in,          // Synchronous reset, high
  input  wire          cmd_valid_in,        // Command request
  input  wire [2:0]    cmd_op_in,           // Command code
  input  wire [AW-1:0] cmd_addr_in,         // Array or sector address
  input  wire [7:0]    cmd_data_in,         // Program data
  output wire          cmd_ready_out,       // Command accepted when high with valid
  output reg           done_ff,             // One-cycle pulse, command ended
  output reg           ok_ff,               // Command succeeded
  output reg           timeout_ff,          // Operation failed on timing limits
  output reg           rejected_ff,         // Added sector not accepted
  output reg  [7:0]    rd_data_ff,          // Last data read
  output reg           dev_busy_ff,         // Sampled busy pin
  output wire [AW-1:0] flash_addr_out,      // Address pins
  output wire [7:0]    flash_data_out,      // Data pins, out
  output wire          flash_data_oe_n_out, // Data drive, low drives
  input  wire [7:0]    flash_data_in,       // Data pins, in
  output wire          flash_ce_n_out,      // Chip select
  output wire          flash_we_n_out,      // Write enable
  output wire          flash_oe_n_out,      // Output enable
  input  wire          ready_busy_n_in      // Ready/busy pin, low busy
);

  localparam S_IDLE = 3'd0;
  localparam S_WR   = 3'd1;
  localparam S_WRW  = 3'd2;
  localparam S_RD   = 3'd3;
  localparam S_RDW  = 3'd4;
  localparam S_FIN  = 3'd5;

  localparam PH_READ = 3'd0;
  localparam PH_PRE  = 3'd1;
  localparam PH_POST = 3'd2;
  localparam PH_P0   = 3'd3;
  localparam PH_P1   = 3'd4;
  localparam PH_P2   = 3'd5;
  localparam PH_P3   = 3'd6;

  reg [2:0]    state_ff;
  reg [2:0]    op_ff;
  reg [2:0]    phase_ff;
  reg [2:0]    step_ff;
  reg [AW-1:0] addr_ff;
  reg [7:0]    data_ff;
  reg          tgl_ff;
  reg          fail_ff;
  reg [15:0]   win_cnt_ff;
  reg          win_open_ff;

  reg          go;
  reg          wr;
  reg [AW-1:0] bus_addr;
  reg [7:0]    bus_data;
  reg [2:0]    last_step;
  wire         bus_idle;
  wire         bus_done;
  wire [7:0]   bus_rdata;
  wire         rd_tgl;

  assign cmd_ready_out = (state_ff == S_IDLE);
  assign rd_tgl        = bus_rdata[`FWSR_BIT_BUSY_TGL];

  ////////////////////////////////////////////////////////////////
  // Write steps of each command sequence
  always @*
  begin
    bus_addr  = `FWSR_ADDR_UNLOCK1;
    bus_data  = `FWSR_DAT_RESET;
    last_step = 3'd0;
    case (op_ff)
      `FWSR_OP_PROG:
      begin
        last_step = 3'd3;
        case (step_ff)
          3'd0:    bus_data = `FWSR_DAT_UNLOCK1;
          3'd1:
          begin
            bus_addr = `FWSR_ADDR_UNLOCK2;
            bus_data = `FWSR_DAT_UNLOCK2;
          end
          3'd2:    bus_data = `FWSR_DAT_PROG;
          default:
          begin
            bus_addr = addr_ff;
            bus_data = data_ff;
          end
        endcase
      end
      `FWSR_OP_ERASE:
      begin
        last_step = 3'd5;
        case (step_ff)
          3'd0, 3'd3: bus_data = `FWSR_DAT_UNLOCK1;
          3'd1, 3'd4:
          begin
            bus_addr = `FWSR_ADDR_UNLOCK2;
            bus_data = `FWSR_DAT_UNLOCK2;
          end
          3'd2:    bus_data = `FWSR_DAT_ERASE_SU;
          default:
          begin
            bus_addr = addr_ff;
            bus_data = `FWSR_DAT_SECT_ERS;
          end
        endcase
      end
      `FWSR_OP_ADD_SECT:
      begin
        bus_addr = addr_ff;
        bus_data = `FWSR_DAT_SECT_ERS;
      end
      default:
      begin
        bus_addr = `FWSR_ADDR_UNLOCK1;
        bus_data = `FWSR_DAT_RESET;
      end
    endcase
    go = (state_ff == S_WR || state_ff == S_RD) && bus_idle;
    wr = (state_ff == S_WR);
    if (state_ff == S_RD)
      bus_addr = addr_ff;
  end

  ////////////////////////////////////////////////////////////////
  always @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      state_ff    <= S_IDLE;
      op_ff       <= `FWSR_OP_READ;
      phase_ff    <= PH_READ;
      step_ff     <= 3'd0;
      addr_ff     <= {AW{1'b0}};
      data_ff     <= 8'h00;
      tgl_ff      <= 1'b0;
      fail_ff     <= 1'b0;
      done_ff     <= 1'b0;
      ok_ff       <= 1'b0;
      timeout_ff  <= 1'b0;
      rejected_ff <= 1'b0;
      rd_data_ff  <= 8'h00;
      dev_busy_ff <= 1'b0;
      win_cnt_ff  <= 16'h0000;
      win_open_ff <= 1'b0;
    end
    else
    begin
      done_ff     <= 1'b0;
      dev_busy_ff <= ~ready_busy_n_in;
      // Loading window restarted when each write cycle of an erase or added sector command ends
      // The write has finished when the bus reports done, so the state is already the wait state
      if (bus_done && (state_ff == S_WRW) && (op_ff == `FWSR_OP_ERASE || op_ff == `FWSR_OP_ADD_SECT))
      begin
        win_cnt_ff  <= 16'h0000;
        win_open_ff <= 1'b1;
      end
      else if (win_cnt_ff >= WIN_CYC[15:0] - 16'h0001)
        win_open_ff <= 1'b0;
      else
        win_cnt_ff <= win_cnt_ff + 16'h0001;
      case (state_ff)
        S_IDLE:
        begin
          if (cmd_valid_in)
          begin
            op_ff       <= cmd_op_in;
            addr_ff     <= cmd_addr_in;
            data_ff     <= cmd_data_in;
            step_ff     <= 3'd0;
            fail_ff     <= 1'b0;
            ok_ff       <= 1'b0;
            timeout_ff  <= 1'b0;
            rejected_ff <= 1'b0;
            case (cmd_op_in)
              `FWSR_OP_READ:
              begin
                phase_ff <= PH_READ;
                state_ff <= S_RD;
              end
              `FWSR_OP_POLL:
              begin
                // Every poll begins with the two-read step
                phase_ff <= PH_P0;
                state_ff <= S_RD;
              end
              `FWSR_OP_ADD_SECT:
              begin
                if (win_open_ff)
                begin
                  phase_ff <= PH_PRE;
                  state_ff <= S_RD;
                end
                else
                begin
                  rejected_ff <= 1'b1;
                  state_ff    <= S_FIN;
                end
              end
              default:
                state_ff <= S_WR;
            endcase
          end
        end
        S_WR:
          if (bus_idle)
            state_ff <= S_WRW;
        S_WRW:
        begin
          if (bus_done)
          begin
            if (step_ff != last_step)
            begin
              step_ff  <= step_ff + 3'd1;
              state_ff <= S_WR;
            end
            else if (op_ff == `FWSR_OP_PROG)
            begin
              phase_ff <= PH_P0;
              state_ff <= S_RD;
            end
            else if (op_ff == `FWSR_OP_ADD_SECT)
            begin
              phase_ff <= PH_POST;
              state_ff <= S_RD;
            end
            else
            begin
              ok_ff      <= ~fail_ff;
              timeout_ff <= fail_ff;
              state_ff   <= S_FIN;
            end
          end
        end
        S_RD:
          if (bus_idle)
            state_ff <= S_RDW;
        S_RDW:
        begin
          if (bus_done)
          begin
            rd_data_ff <= bus_rdata;
            state_ff   <= S_RD;
            case (phase_ff)
              PH_PRE:
              begin
                if (bus_rdata[`FWSR_BIT_WINDOW])
                begin
                  rejected_ff <= 1'b1;
                  state_ff    <= S_FIN;
                end
                else
                  state_ff <= S_WR;
              end
              PH_POST:
              begin
                rejected_ff <= bus_rdata[`FWSR_BIT_WINDOW];
                ok_ff       <= ~bus_rdata[`FWSR_BIT_WINDOW];
                state_ff    <= S_FIN;
              end
              PH_P0, PH_P2:
              begin
                tgl_ff   <= rd_tgl;
                phase_ff <= phase_ff + 3'd1;
              end
              PH_P1:
              begin
                if (rd_tgl == tgl_ff)
                begin
                  ok_ff    <= 1'b1;
                  state_ff <= S_FIN;
                end
                else if (bus_rdata[`FWSR_BIT_TIMING])
                  phase_ff <= PH_P2;
                else
                  phase_ff <= PH_P0;
              end
              PH_P3:
              begin
                if (rd_tgl == tgl_ff)
                begin
                  ok_ff    <= 1'b1;
                  state_ff <= S_FIN;
                end
                else
                begin
                  // Failed operation: reset is written before anything else can start
                  fail_ff  <= 1'b1;
                  op_ff    <= `FWSR_OP_RESET;
                  step_ff  <= 3'd0;
                  state_ff <= S_WR;
                end
              end
              default:
              begin
                ok_ff    <= 1'b1;
                state_ff <= S_FIN;
              end
            endcase
          end
        end
        S_FIN:
        begin
          done_ff  <= 1'b1;
          state_ff <= S_IDLE;
        end
        default:
          state_ff <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  fwsr_bus_cycle #(
    .AW (AW)
  ) u_bus (
    .sys_clk_in          (sys_clk_in),
    .sys_rst_in          (sys_rst_in),
    .go_in               (go),
    .wr_in               (wr),
    .addr_in             (bus_addr),
    .wdata_in            (bus_data),
    .idle_out            (bus_idle),
    .done_ff             (bus_done),
    .rdata_ff            (bus_rdata),
    .flash_addr_out      (flash_addr_out),
    .flash_data_out      (flash_data_out),
    .flash_data_oe_n_out (flash_data_oe_n_out),
    .flash_data_in       (flash_data_in),
    .flash_ce_n_out      (flash_ce_n_out),
    .flash_we_n_out      (flash_we_n_out),
    .flash_oe_n_out      (flash_oe_n_out)
  );

endmodule // fwsr_host_ctrl

// ===== tb/fwsr_host_ctrl_asserts.sv
`timescale 1ns/10ps
module fwsr_host_ctrl_chk #(
  parameter AW = 20
) (
  input wire          sys_clk_in,          // Clock
  input wire          sys_rst_in,          // Reset
  input wire          cmd_ready_out,       // Idle
  input wire          done_ff,             // End pulse
  input wire          ok_ff,               // Success
  input wire          timeout_ff,          // Failed
  input wire          rejected_ff,         // Refused sector
  input wire [AW-1:0] flash_addr_out,      // Address
  input wire          flash_data_oe_n_out, // Data drive
  input wire          flash_ce_n_out,      // Chip select
  input wire          flash_we_n_out,      // Write enable
  input wire          flash_oe_n_out       // Output enable
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  ////////////////////////////////////////////////////////////////////////////
  a_write_inhibit: assert property (!flash_we_n_out |-> !flash_ce_n_out && flash_oe_n_out && !flash_data_oe_n_out)
    else $error("write strobe without select or with output enable");
  a_no_contention: assert property (!flash_oe_n_out |-> flash_data_oe_n_out)
    else $error("host drives data during a read");
  a_we_width: assert property ($fell(flash_we_n_out) |=> !flash_we_n_out ##1 flash_we_n_out)
    else $error("write pulse not two cycles");
  a_we_gap: assert property ($rose(flash_we_n_out) |-> flash_we_n_out[*2])
    else $error("write high time too short");
  a_read_width: assert property ($fell(flash_oe_n_out) |-> !flash_oe_n_out[*3] ##1 flash_oe_n_out)
    else $error("read strobe not three cycles");
  a_addr_hold: assert property (!flash_ce_n_out && $past(!flash_ce_n_out) |-> $stable(flash_addr_out))
    else $error("address moved under chip select");
  a_idle_quiet: assert property (cmd_ready_out |-> flash_ce_n_out && flash_we_n_out && flash_oe_n_out)
    else $error("bus active while idle");
  a_done_single: assert property (done_ff |-> cmd_ready_out ##1 !done_ff)
    else $error("done not a single pulse");
  a_fail_not_ok: assert property (done_ff && timeout_ff |-> !ok_ff)
    else $error("timeout reported as success");
  a_reject_not_ok: assert property (done_ff && rejected_ff |-> !ok_ff)
    else $error("refused sector reported as success");
endmodule // fwsr_host_ctrl_chk

bind fwsr_host_ctrl fwsr_host_ctrl_chk #(.AW(AW)) u_chk (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
  .cmd_ready_out(cmd_ready_out), .done_ff(done_ff), .ok_ff(ok_ff), .timeout_ff(timeout_ff),
  .rejected_ff(rejected_ff), .flash_addr_out(flash_addr_out), .flash_data_oe_n_out(flash_data_oe_n_out),
  .flash_ce_n_out(flash_ce_n_out), .flash_we_n_out(flash_we_n_out), .flash_oe_n_out(flash_oe_n_out));

// ===== tb/fwsr_flash_model.sv
`timescale 1ns/10ps
module fwsr_flash_model #(
  parameter AW       = 20,
  parameter BUSY_CYC = 20,
  parameter WIN_CYC  = 50
) (
  input  wire          sys_clk_in,      // Sampling clock
  input  wire [AW-1:0] addr_in,         // Address pins
  input  wire [7:0]    data_in,         // Data pins
  input  wire          ce_n_in,         // Chip select
  input  wire          we_n_in,         // Write enable
  input  wire          oe_n_in,         // Output enable
  input  wire          fail_in,         // Force pulse limit failure
  output wire [7:0]    data_out,        // Data to host
  output wire          ready_busy_n_out // Low while busy
);
  reg  [7:0]  mem [0:255];
  reg  [15:0] sel;
  reg  [7:0]  wa, wd, pd, last;
  reg  [2:0]  seq;
  reg         wl, rl, prog, ers, closed, tmo, tb6, tb2;
  integer     cnt, i;
  wire        rd   = !ce_n_in && !oe_n_in;
  wire        hit  = sel[addr_in[7:4]];
  wire        busy = prog || ers || tmo;
  wire [7:0]  st   = {ers ? 1'b0 : ~pd[7], tb6, tmo, 1'b0, ers & closed, ers & hit & tb2, 2'b00};
  assign ready_busy_n_out = !busy;
  // A released bus shows the inverse of its last value, so stale data never matches
  assign data_out = !rd ? ~last : busy ? st : mem[addr_in[7:0]];
  initial
  begin
    for (i = 0; i < 256; i = i + 1) mem[i] = 8'hFF;
    {wl, rl, prog, ers, closed, tmo, tb6, tb2} = 8'h00;
    {sel, seq, cnt, last, pd} = 0;
  end
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk_in)
  begin
    // Sampled per clock, so sub-cycle glitches never form a write
    wl <= !ce_n_in && !we_n_in && oe_n_in;
    if (!ce_n_in && !we_n_in && oe_n_in) {wa, wd} <= {addr_in[7:0], data_in};
    rl <= rd;
    if (rd) last <= data_out;
    if (rl && !rd && busy) {tb6, tb2} <= {~tb6, (ers && hit) ? ~tb2 : tb2};
    if (ers && !closed)
    begin
      cnt <= cnt + 1;
      if (cnt >= WIN_CYC) {closed, cnt} <= {1'b1, 32'd0};
    end
    else if (busy && !tmo)
    begin
      cnt <= cnt + 1;
      if (cnt >= BUSY_CYC && fail_in) tmo <= 1'b1;
      else if (cnt >= BUSY_CYC)
      begin
        for (i = 0; i < 256; i = i + 1) if (sel[i >> 4]) mem[i] <= 8'hFF;
        {prog, ers, closed, sel, seq} <= 0;
      end
    end
    if (wl && we_n_in)
    begin
      if (tmo || seq == 3'd7 && wd != 8'h30)
      begin
        if (!tmo || wd == 8'hF0) {tmo, prog, ers, closed, sel, seq} <= 0;
      end
      else if (prog || closed) seq <= seq;
      else if (seq == 3'd7) {sel[wa[7:4]], cnt} <= {1'b1, 32'd0};
      else case (seq)
        3'd0: seq <= (wa == 8'h55 && wd == 8'hAA) ? 3'd1 : 3'd0;
        3'd1: seq <= (wa == 8'hAA && wd == 8'h55) ? 3'd2 : 3'd0;
        3'd2: seq <= wa != 8'h55 ? 3'd0 : wd == 8'hA0 ? 3'd3 : wd == 8'h80 ? 3'd4 : 3'd0;
        3'd3: {mem[wa], pd, prog, cnt, seq} <= {mem[wa] & wd, wd, 1'b1, 32'd0, 3'd0};
        3'd4: seq <= (wa == 8'h55 && wd == 8'hAA) ? 3'd5 : 3'd0;
        3'd5: seq <= (wa == 8'hAA && wd == 8'h55) ? 3'd6 : 3'd0;
        default: if (wd == 8'h30) {sel[wa[7:4]], ers, cnt, seq} <= {2'b11, 32'd0, 3'd7};
                 else seq <= 3'd0;
      endcase
    end
  end
endmodule // fwsr_flash_model

// ===== tb/fwsr_host_ctrl_test.sv
`timescale 1ns/10ps
module fwsr_host_ctrl_test;
  reg          sys_clk_in, sys_rst_in, cmd_valid_in, fail_in;
  reg  [2:0]   cmd_op_in;
  reg  [19:0]  cmd_addr_in;
  reg  [7:0]   cmd_data_in;
  wire         cmd_ready_out, done_ff, ok_ff, timeout_ff, rejected_ff, dev_busy_ff;
  wire [7:0]   rd_data_ff, host_q, dev_q, flash_data_in;
  wire [19:0]  flash_addr_out;
  wire         data_oe_n, ce_n, we_n, oe_n, ready_busy_n;
  integer      failures, tests_run, cycles;
  // Host wins the data pins only while its enable is low
  assign flash_data_in = data_oe_n ? dev_q : host_q;
  fwsr_host_ctrl #(.AW(20), .WIN_CYC(50)) dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .cmd_valid_in(cmd_valid_in), .cmd_op_in(cmd_op_in), .cmd_addr_in(cmd_addr_in), .cmd_data_in(cmd_data_in),
    .cmd_ready_out(cmd_ready_out), .done_ff(done_ff), .ok_ff(ok_ff), .timeout_ff(timeout_ff),
    .rejected_ff(rejected_ff), .rd_data_ff(rd_data_ff), .dev_busy_ff(dev_busy_ff),
    .flash_addr_out(flash_addr_out), .flash_data_out(host_q), .flash_data_oe_n_out(data_oe_n),
    .flash_data_in(flash_data_in), .flash_ce_n_out(ce_n), .flash_we_n_out(we_n), .flash_oe_n_out(oe_n),
    .ready_busy_n_in(ready_busy_n));
  fwsr_flash_model #(.AW(20), .BUSY_CYC(20), .WIN_CYC(50)) u_flash (.sys_clk_in(sys_clk_in),
    .addr_in(flash_addr_out), .data_in(flash_data_in), .ce_n_in(ce_n), .we_n_in(we_n), .oe_n_in(oe_n),
    .fail_in(fail_in), .data_out(dev_q), .ready_busy_n_out(ready_busy_n));
  ////////////////////////////////////////////////////////////////////////////
  task check(input [8*10-1:0] name, input [7:0] seen, input [7:0] exp);
  begin
    tests_run = tests_run + 1;
    if (seen !== exp)
    begin
      failures = failures + 1;
      $display("BAD %0s expected %h seen %h", name, exp, seen);
    end
  end
  endtask
  task cmd(input [2:0] op, input [19:0] a, input [7:0] d);
    integer n;
  begin
    @(posedge sys_clk_in);
    {cmd_valid_in, cmd_op_in, cmd_addr_in, cmd_data_in} <= {1'b1, op, a, d};
    @(posedge sys_clk_in);
    while (cmd_ready_out !== 1'b1) @(posedge sys_clk_in);
    cmd_valid_in <= 1'b0;
    n = 0;
    while (done_ff !== 1'b1 && n < 3000)
    begin
      @(posedge sys_clk_in);
      n = n + 1;
    end
    if (n >= 3000)
    begin
      failures = failures + 1;
      $display("BAD done_ff expected 1 seen 0");
    end
  end
  endtask
  task complete_run;
  begin
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end
  // Whole run needs several hundred cycles; the ceiling leaves a wide margin
  always @(posedge sys_clk_in)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      failures = failures + 1;
      complete_run;
    end
  end
  initial
  begin
    {failures, tests_run, cycles} = 0;
    {sys_rst_in, cmd_valid_in, fail_in, cmd_op_in, cmd_addr_in, cmd_data_in} = 34'h2_0000_0000;
    repeat (3) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    check("idle_pins", {4'h0, cmd_ready_out, ce_n, we_n, oe_n}, 8'h0F);
    cmd(3'h0, 20'h0_0010, 8'h00);
    check("rd_pwrup", rd_data_ff, 8'hFF);
    cmd(3'h1, 20'h0_0012, 8'h5A);
    check("prog_ok", {timeout_ff, ok_ff}, 8'h01);
    cmd(3'h0, 20'h0_0012, 8'h00);
    check("prog_rd", rd_data_ff, 8'h5A);
    cmd(3'h1, 20'h0_0012, 8'hA5);
    check("reprog_ok", {timeout_ff, ok_ff}, 8'h01);
    cmd(3'h0, 20'h0_0012, 8'h00);
    check("reprog_rd", rd_data_ff, 8'h00);
    cmd(3'h1, 20'h0_0031, 8'h00);
    $display("test program done");
    cmd(3'h2, 20'h0_0020, 8'h00);
    check("erase_ok", {rejected_ff, ok_ff}, 8'h01);
    check("erase_busy", {7'h00, dev_busy_ff}, 8'h01);
    cmd(3'h3, 20'h0_0030, 8'h00);
    check("add_ok", {rejected_ff, ok_ff}, 8'h01);
    cmd(3'h4, 20'h0_0020, 8'h00);
    check("poll_ok", {timeout_ff, ok_ff}, 8'h01);
    cmd(3'h0, 20'h0_0031, 8'h00);
    check("added_rd", rd_data_ff, 8'hFF);
    cmd(3'h0, 20'h0_0012, 8'h00);
    check("other_rd", rd_data_ff, 8'h00);
    $display("test erase done");
    cmd(3'h2, 20'h0_0040, 8'h00);
    repeat (55) @(posedge sys_clk_in);
    cmd(3'h3, 20'h0_0050, 8'h00);
    check("add_late", {rejected_ff, ok_ff}, 8'h02);
    cmd(3'h4, 20'h0_0040, 8'h00);
    check("poll_late", {timeout_ff, ok_ff}, 8'h01);
    $display("test window done");
    fail_in <= 1'b1;
    cmd(3'h1, 20'h0_0060, 8'h00);
    check("fail", {timeout_ff, ok_ff}, 8'h02);
    fail_in <= 1'b0;
    cmd(3'h1, 20'h0_0061, 8'h3C);
    check("after_fail", {timeout_ff, ok_ff}, 8'h01);
    cmd(3'h0, 20'h0_0061, 8'h00);
    check("after_rd", rd_data_ff, 8'h3C);
    cmd(3'h5, 20'h0_0000, 8'h00);
    check("reset_op", {7'h00, dev_busy_ff}, 8'h00);
    $display("test fault done");
    complete_run;
  end
endmodule // fwsr_host_ctrl_test
